// ---- logic/gsw_pin_sync.sv ----
`default_nettype none
// Two-stage synchroniser followed by sticky capture for one pin.
module gsw_pin_sync
    import gsw_pkg::*;
(
    input wire logic sys_clk,
    input wire logic por,
    input wire logic pin_raw,
    input wire logic active_low,
    input wire logic sticky_en,
    input wire logic clear_req,
    output logic level,
    output logic sticky
);
    logic meta_r, meta_nxt, level_r, level_nxt, sticky_r, sticky_nxt;
    logic hit;

    // Capture wins over a clear in the same cycle so no event is lost.
    always_comb begin
        meta_nxt = pin_raw;
        level_nxt = meta_r;
        hit = (level_r ^ active_low);
        sticky_nxt = sticky_r;
        if (clear_req) begin
            sticky_nxt = 1'b0;
        end
        if (hit) begin
            sticky_nxt = 1'b1;
        end
        if (!sticky_en) begin
            sticky_nxt = 1'b0;
        end
    end

    // Of the two resets, only power-up returns the capture to its default.
    always_ff @(posedge sys_clk) begin
        meta_r <= meta_nxt;
        level_r <= level_nxt;
        if (por) begin
            sticky_r <= 1'b0;
        end else begin
            sticky_r <= sticky_nxt;
        end
    end

    assign level = level_r;
    assign sticky = sticky_r;

    chk_sticky_off: assert property (
        @(posedge sys_clk) disable iff (por)
        !sticky_en |=> !sticky_r)
        else $error("sticky set while off");
    chk_sticky_set: assert property (
        @(posedge sys_clk) disable iff (por)
        (sticky_en && hit) |=> sticky_r)
        else $error("capture missed");
endmodule : gsw_pin_sync
`default_nettype wire

// ---- logic/gsw_pkg.sv ----
`default_nettype none
package gsw_pkg;
    // Register offsets within the codec's control space.
    localparam logic [7:0] GSW_OFS_DIRECTION = 8'h4c;
    localparam logic [7:0] GSW_OFS_POLARITY = 8'h4e;
    localparam logic [7:0] GSW_OFS_STICKY_SEL = 8'h50;
    localparam logic [7:0] GSW_OFS_WAKE_MASK = 8'h52;
    localparam logic [7:0] GSW_OFS_STATE = 8'h54;
    // Power-up defaults.
    localparam logic [7:0] GSW_RST_DIRECTION = 8'hff;
    localparam logic [7:0] GSW_RST_POLARITY = 8'hff;
    localparam logic [7:0] GSW_RST_STICKY_SEL = 8'h00;
    localparam logic [7:0] GSW_RST_WAKE_MASK = 8'h00;
    localparam logic [7:0] GSW_RST_OUT_LEVEL = 8'hff;
    // Pin numbers with fixed roles.
    localparam int GSW_PIN_INPUT_ONLY = 1;
    localparam int GSW_PIN_WAKE = 3;
    // Interrupt bit position in slot 12.
    localparam int GSW_SLOT12_IRQ_BIT = 0;
    localparam int GSW_PINS = 8;
    // Serial interface modes.
    typedef enum logic [0:0] {
        GSW_MODE_AC97 = 1'b0,
        GSW_MODE_DSP = 1'b1
    } gsw_mode_t;
endpackage : gsw_pkg
`default_nettype wire

// ---- logic/gsw_top.sv ----
`default_nettype none
module gsw_top
    import gsw_pkg::*;
#(
    parameter int NPINS = GSW_PINS
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic por,
    input wire logic serial_mode,
    input wire logic link_reset_n,
    input wire logic [NPINS-1:0] alt_func,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    input wire logic [NPINS-1:0] slot12_out_bits,
    input wire logic slot12_valid,
    output logic slot12_irq,
    output logic [NPINS-1:0] pin_in_sample,
    input wire logic [NPINS-1:0] pin_i,
    output logic [NPINS-1:0] pin_o,
    output logic [NPINS-1:0] pin_oe,
    output logic [NPINS-1:0] pin_pullup,
    output logic wake_o,
    output logic wake_oe,
    output logic sdata_in_wake
);
    // Pin roles are fixed per number, so no other count can be served.
    if (NPINS != GSW_PINS) begin : g_bad_npins
        $error("gsw_top serves exactly eight pins");
    end

    logic [NPINS-1:0] pin_direction_r, pin_direction_nxt;
    logic [NPINS-1:0] pin_polarity_type_r, pin_polarity_type_nxt;
    logic [NPINS-1:0] pin_sticky_select_bits_r, pin_sticky_select_bits_nxt;
    logic [NPINS-1:0] pin_wake_mask_bits_r, pin_wake_mask_bits_nxt;
    logic [NPINS-1:0] out_level_r, out_level_nxt;
    logic [NPINS-1:0] live, sticky, clear_req, is_out, state_bits;
    logic [NPINS-1:0] pin_o_nxt, pin_oe_nxt, pull_nxt;
    logic [15:0] rdata_nxt;
    logic irq, wake_pin_select;
    logic irq_r, wake_o_r, wake_oe_r, sdin_r;
    logic [NPINS-1:0] pin_o_r, pin_oe_r, pull_r, sample_r;
    logic [15:0] rdata_r;

    // Pin 3 serves as wake output when it is flagged for an alternate role.
    assign wake_pin_select = alt_func[GSW_PIN_WAKE];

    // One synchroniser and capture per pin.
    for (genvar i = 0; i < NPINS; i++) begin : g_pin
        gsw_pin_sync u_sync (
            .sys_clk(sys_clk),
            .por(por),
            .pin_raw(pin_i[i]),
            .active_low(pin_polarity_type_r[i]),
            .sticky_en(pin_sticky_select_bits_r[i]),
            .clear_req(clear_req[i]),
            .level(live[i]),
            .sticky(sticky[i])
        );
    end

    // Register writes; a write of 0 to a status bit requests a clear.
    always_comb begin
        pin_direction_nxt = pin_direction_r;
        pin_polarity_type_nxt = pin_polarity_type_r;
        pin_sticky_select_bits_nxt = pin_sticky_select_bits_r;
        pin_wake_mask_bits_nxt = pin_wake_mask_bits_r;
        out_level_nxt = out_level_r;
        clear_req = '0;
        if (reg_wr) begin
            unique case (reg_addr)
                GSW_OFS_DIRECTION: pin_direction_nxt = reg_wdata[7:0];
                GSW_OFS_POLARITY: pin_polarity_type_nxt = reg_wdata[7:0];
                GSW_OFS_STICKY_SEL: begin
                    pin_sticky_select_bits_nxt = reg_wdata[7:0];
                end
                GSW_OFS_WAKE_MASK: pin_wake_mask_bits_nxt = reg_wdata[7:0];
                GSW_OFS_STATE: begin
                    clear_req = ~reg_wdata[7:0];
                    if (serial_mode == GSW_MODE_DSP) begin
                        out_level_nxt = reg_wdata[7:0];
                    end
                end
                default: ;
            endcase
        end
        // In AC'97 mode the link's slot 12 owns output levels.
        if (serial_mode == GSW_MODE_AC97 && slot12_valid) begin
            out_level_nxt = slot12_out_bits;
        end
    end

    // Pin drive, status view and interrupt combine.
    always_comb begin
        is_out = ~pin_direction_r & ~alt_func;
        is_out[GSW_PIN_INPUT_ONLY] = 1'b0;
        state_bits = pin_sticky_select_bits_r & sticky
            | ~pin_sticky_select_bits_r & live;
        irq = |(sticky & pin_wake_mask_bits_r);
        pin_o_nxt = is_out & out_level_r;
        // Open drain only pulls low; push-pull drives both levels.
        pin_oe_nxt = is_out & (~pin_polarity_type_r | ~out_level_r);
        pull_nxt = pin_polarity_type_r;
        rdata_nxt = 16'h0000;
        unique case (reg_addr)
            GSW_OFS_DIRECTION: rdata_nxt[7:0] = pin_direction_r;
            GSW_OFS_POLARITY: rdata_nxt[7:0] = pin_polarity_type_r;
            GSW_OFS_STICKY_SEL: rdata_nxt[7:0] = pin_sticky_select_bits_r;
            GSW_OFS_WAKE_MASK: rdata_nxt[7:0] = pin_wake_mask_bits_r;
            GSW_OFS_STATE: rdata_nxt[7:0] = state_bits;
            default: ;
        endcase
    end

    // Configuration survives the link reset; only power-up restores it.
    always_ff @(posedge sys_clk) begin
        if (por) begin
            pin_direction_r <= GSW_RST_DIRECTION;
            pin_polarity_type_r <= GSW_RST_POLARITY;
            pin_sticky_select_bits_r <= GSW_RST_STICKY_SEL;
            pin_wake_mask_bits_r <= GSW_RST_WAKE_MASK;
            out_level_r <= GSW_RST_OUT_LEVEL;
        end else begin
            pin_direction_r <= pin_direction_nxt;
            pin_polarity_type_r <= pin_polarity_type_nxt;
            pin_sticky_select_bits_r <= pin_sticky_select_bits_nxt;
            pin_wake_mask_bits_r <= pin_wake_mask_bits_nxt;
            out_level_r <= out_level_nxt;
        end
    end

    // Output stage; rst gives a quiet pin state for one cycle onward.
    always_ff @(posedge sys_clk) begin
        if (rst || por) begin
            irq_r <= 1'b0;
            wake_o_r <= 1'b0;
            wake_oe_r <= 1'b0;
            sdin_r <= 1'b0;
            pin_o_r <= '0;
            pin_oe_r <= '0;
            pull_r <= '1;
            sample_r <= '0;
            rdata_r <= 16'h0000;
        end else begin
            irq_r <= (serial_mode == GSW_MODE_AC97) & irq;
            wake_o_r <= wake_pin_select & irq;
            wake_oe_r <= wake_pin_select;
            sdin_r <= (serial_mode == GSW_MODE_AC97) & ~link_reset_n
                & irq;
            pin_o_r <= pin_o_nxt;
            pin_oe_r <= pin_oe_nxt;
            pull_r <= pull_nxt;
            sample_r <= live;
            rdata_r <= rdata_nxt;
        end
    end

    assign slot12_irq = irq_r;
    assign wake_o = wake_o_r;
    assign wake_oe = wake_oe_r;
    assign sdata_in_wake = sdin_r;
    assign pin_o = pin_o_r;
    assign pin_oe = pin_oe_r;
    assign pin_pullup = pull_r;
    assign pin_in_sample = sample_r;
    assign reg_rdata = rdata_r;

    chk_wake_pin: assert property (
        @(posedge sys_clk) disable iff (rst || por)
        (wake_pin_select && irq) |=> wake_o)
        else $error("wake pin low");
    chk_slot_irq: assert property (
        @(posedge sys_clk) disable iff (rst || por)
        (serial_mode == GSW_MODE_AC97) |=> slot12_irq == $past(irq))
        else $error("slot irq wrong");
    chk_irq_mask: assert property (
        @(posedge sys_clk) disable iff (rst || por)
        (pin_wake_mask_bits_r == 8'h00) |-> !irq)
        else $error("irq unmasked");
    chk_pin1_input: assert property (
        @(posedge sys_clk) disable iff (rst || por)
        !pin_oe[GSW_PIN_INPUT_ONLY])
        else $error("pin 1 driven");
    chk_sdin_wake: assert property (
        @(posedge sys_clk) disable iff (rst || por)
        (serial_mode == GSW_MODE_AC97 && !link_reset_n && irq)
        |=> sdata_in_wake)
        else $error("no wake on data-in");
    chk_dsp_level: assert property (
        @(posedge sys_clk) disable iff (rst || por)
        (reg_wr && reg_addr == GSW_OFS_STATE && serial_mode == GSW_MODE_DSP)
        |=> out_level_r == $past(reg_wdata[7:0]))
        else $error("dsp level");
    chk_in_no_drive: assert property (
        @(posedge sys_clk) disable iff (rst || por)
        ##1 ((pin_oe & $past(pin_direction_r)) == 8'h00))
        else $error("input driven");
    chk_od_high: assert property (
        @(posedge sys_clk) disable iff (rst || por)
        ##1 ((pin_oe & pin_o & $past(pin_polarity_type_r)) == 8'h00))
        else $error("open drain drove high");
endmodule : gsw_top
`default_nettype wire

// ---- verif/gsw_pin_model.sv ----
`default_nettype none
// Pad-side stand-in: resolves each pad from the block's drive and ours.
module gsw_pin_model (
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pullup,
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_oe,
    output logic [7:0] pin_lvl
);
    timeunit 1ns;
    timeprecision 1ps;
    // An undriven pad without pull-up reads the inverse of our last value,
    // so a design that samples a floating pin cannot pass by luck.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (ext_oe[i]) pin_lvl[i] = ext_val[i];
            else if (pin_oe[i]) pin_lvl[i] = pin_o[i];
            else pin_lvl[i] = pin_pullup[i] | ~ext_val[i];
        end
    end
endmodule // gsw_pin_model
`default_nettype wire

// ---- verif/gsw_top_tb.sv ----
`default_nettype none
module gsw_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import gsw_pkg::*;
    logic sys_clk, rst, por, serial_mode, link_reset_n, reg_wr, slot12_valid;
    logic slot12_irq, wake_o, wake_oe, sdata_in_wake;
    logic [7:0] alt_func, reg_addr, slot12_out_bits, pin_in_sample, pin_i;
    logic [7:0] pin_o, pin_oe, pin_pullup, ext_val, ext_oe;
    logic [15:0] reg_wdata, reg_rdata, d;
    int num_errors = 0;
    int tests_run = 0;
    // Columns: pins, polarity, sticky select, mask, status read, interrupt.
    logic [5:0][7:0] rows [5] = '{
        {8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'h00},
        {8'h0f, 8'hff, 8'hff, 8'h00, 8'hf0, 8'h00},
        {8'h0f, 8'h00, 8'hf0, 8'h01, 8'h0f, 8'h00},
        {8'h3c, 8'h00, 8'hff, 8'h04, 8'h3c, 8'h01},
        {8'hc3, 8'hff, 8'hff, 8'hff, 8'h3c, 8'h01}};

    gsw_top i_gsw_top (.sys_clk(sys_clk), .rst(rst), .por(por),
        .serial_mode(serial_mode), .link_reset_n(link_reset_n),
        .alt_func(alt_func), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .slot12_out_bits(slot12_out_bits), .slot12_valid(slot12_valid),
        .slot12_irq(slot12_irq), .pin_in_sample(pin_in_sample),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .wake_o(wake_o), .wake_oe(wake_oe),
        .sdata_in_wake(sdata_in_wake));
    gsw_pin_model i_gsw_pin_model (.pin_o(pin_o), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .ext_val(ext_val), .ext_oe(ext_oe),
        .pin_lvl(pin_i));

    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // One-cycle write strobe; the next access waits for a fresh edge.
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        cyc(2);
        #1 v = reg_rdata;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // A hang counts as a mismatch and still reaches the verdict.
    initial begin
        repeat (5000) @(posedge sys_clk);
        num_errors++;
        complete_run();
    end
    initial begin
        {rst, por, link_reset_n} = 3'b111;
        {serial_mode, reg_wr, slot12_valid} = 3'b000;
        {alt_func, reg_addr, slot12_out_bits, reg_wdata} = '0;
        ext_val = 8'hff;
        ext_oe = 8'hff;
        cyc(3);
        rst <= 1'b0;
        por <= 1'b0;
        // Stickies are cleared through the select before each row.
        for (int r = 0; r < 5; r++) begin
            wr(GSW_OFS_STICKY_SEL, 16'h0000);
            ext_val <= rows[r][5];
            wr(GSW_OFS_POLARITY, {8'h00, rows[r][4]});
            cyc(4);
            wr(GSW_OFS_STICKY_SEL, {8'h00, rows[r][3]});
            wr(GSW_OFS_WAKE_MASK, {8'h00, rows[r][2]});
            cyc(4);
            rd(GSW_OFS_STATE, d);
            chk(d, {8'h00, rows[r][1]});
            chk({8'h00, pin_pullup}, {8'h00, rows[r][4]});
            chk({15'h0, slot12_irq}, {8'h00, rows[r][0]});
            chk({15'h0, wake_o}, 16'h0000);
            chk({15'h0, wake_oe}, 16'h0000);
            chk({8'h00, pin_in_sample}, {8'h00, rows[r][5]});
        end
        // Pins go idle; a zero write clears one sticky, ones leave the rest.
        // The old active level must leave the synchroniser first, or a
        // late capture would win over the clear in the same cycle.
        cyc(1);
        ext_val <= 8'hff;
        cyc(4);
        wr(GSW_OFS_STATE, 16'h00fb);
        wr(GSW_OFS_STATE, 16'h00ff);
        rd(GSW_OFS_STATE, d);
        chk(d, 16'h0038);
        link_reset_n <= 1'b0;
        alt_func <= 8'h08;
        cyc(4);
        chk({15'h0, sdata_in_wake}, 16'h0001);
        chk({15'h0, wake_o}, 16'h0001);
        chk({15'h0, slot12_irq}, 16'h0001);
        chk({15'h0, wake_oe}, 16'h0001);
        link_reset_n <= 1'b1;
        rst <= 1'b1;
        cyc(1);
        rst <= 1'b0;
        // The output stage is quiet for the cycle after the reset edge.
        #1 chk({14'h0, wake_o, wake_oe}, 16'h0000);
        chk({8'h00, pin_pullup}, 16'h00ff);
        rd(GSW_OFS_STICKY_SEL, d);
        chk(d, 16'h00ff);
        rd(GSW_OFS_STATE, d);
        chk(d, 16'h0038);
        // DSP mode: status writes drive the outputs, pin 1 and pin 3 excepted.
        serial_mode <= 1'b1;
        ext_oe <= 8'h02;
        wr(GSW_OFS_DIRECTION, 16'h0000);
        wr(GSW_OFS_POLARITY, 16'h0000);
        wr(GSW_OFS_STATE, 16'h00a5);
        cyc(3);
        chk({8'h00, pin_oe}, 16'h00f5);
        chk({8'h00, pin_o & pin_oe}, 16'h00a5);
        chk({15'h0, slot12_irq}, 16'h0000);
        wr(GSW_OFS_POLARITY, 16'h00ff);
        cyc(3);
        chk({8'h00, pin_oe}, 16'h0050);
        chk({8'h00, pin_pullup}, 16'h00ff);
        // AC'97 mode: levels follow the frame, status writes do not.
        serial_mode <= 1'b0;
        wr(GSW_OFS_POLARITY, 16'h0000);
        slot12_out_bits <= 8'h3c;
        slot12_valid <= 1'b1;
        cyc(1);
        slot12_valid <= 1'b0;
        wr(GSW_OFS_STATE, 16'h00ff);
        cyc(3);
        chk({8'h00, pin_o & pin_oe}, 16'h0034);
        por <= 1'b1;
        ext_oe <= 8'hff;
        cyc(1);
        por <= 1'b0;
        cyc(4);
        rd(GSW_OFS_STICKY_SEL, d);
        chk(d, 16'h0000);
        rd(GSW_OFS_WAKE_MASK, d);
        chk(d, 16'h0000);
        rd(GSW_OFS_STATE, d);
        chk(d, 16'h00ff);
        rd(8'h60, d);
        chk(d, 16'h0000);
        complete_run();
    end
endmodule // gsw_top_tb
`default_nettype wire
